// File: hw/slpm_top.v
// strap latch and host/panel pin mapping with apb configuration registers
// Function
// [R1] sample straps once at reset release
// [R2] ignore strap changes until next reset
// [R3] low host select: 80 style, rd/wr strobes
// [R4] high host select: 68 style interface
// [R5] byte order strap 1 big, 0 little
// [R6] reserved strap held low by system
// [R7] panel pins follow two-bit panel field
// [R8] 68 style: strobes and direction remap
`timescale 1ns/1ns
`default_nettype none
`include "slpm_map.vh"
module slpm_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [2:0] config_straps,
   input wire host_cs_n,
   input wire host_rd_pin_n,
   input wire host_wr_pin_n,
   input wire [2:0] host_addr_bus,
   output reg host_rd_strobe_n,
   output reg host_wr_strobe_n,
   output reg host_cs_out_n,
   output reg [2:0] host_addr_out,
   output reg big_endian,
   output reg host_bus_68,
   output reg strap_fault,
   input wire pnl_vsync,
   input wire pnl_hsync,
   input wire pnl_dclk,
   input wire pnl_den,
   input wire pnl_ser_cs_n,
   input wire pnl_ser_clk,
   input wire pnl_ser_a0,
   input wire pnl_ser_do,
   input wire pnl_par_wr_n,
   input wire pnl_par_a0,
   input wire pnl_par_cs_n,
   output reg pin_frame,
   output reg pin_line,
   output reg pin_shift,
   output reg pin_drdy,
   output reg pin_cs1_n,
   output reg pin_sck,
   output reg pin_a0,
   output reg pin_so,
   output reg [1:0] panel_mode
);
   //*************************************************
   // decode functions
   //*************************************************
   // pure decodes shared by the output stages; no state lives here
   // host strobes from the rd and wr pins by host bus style;
   // the result is {rd strobe, wr strobe}, both active low
   function [1:0] slpm_host_strobes;
      input style_68; // captured host bus select, 1 for 68 style
      input rd_pin_n; // read pin, the data strobe in 68 style
      input wr_pin_n; // write pin, the direction in 68 style
      begin
         if (!style_68) begin
            // 80 style: read and write strobes pass straight through
            slpm_host_strobes = {rd_pin_n, wr_pin_n}; // see [R3]
         end else begin
            // 68 style: direction high reads, low writes, both gated
            // by the data strobe
            slpm_host_strobes[1] = rd_pin_n | ~wr_pin_n; // see [R4]
            slpm_host_strobes[0] = rd_pin_n | wr_pin_n; // see [R8]
         end
      end
   endfunction

   // register select on the full byte address; misaligned or
   // unmapped addresses select nothing and end in an error response
   function slpm_hit;
      input [`SLPM_ADDR_W-1:0] addr; // bus byte address
      input [`SLPM_ADDR_W-1:0] target; // register byte address
      begin
         slpm_hit = (addr == target);
      end
   endfunction

   //*************************************************
   // pin synchronisers
   //*************************************************
   reg [2:0] strap_s1_ff; // first stage, read only by second
   reg [2:0] strap_s2_ff; // synchronised straps
   reg [4:0] host_s1_ff; // first stage host pins
   reg [4:0] host_s2_ff; // synchronised host pins
   wire [2:0] straps_cfg; // latched strap set
   wire strap_done; // strap capture completed
   reg [1:0] panel_mode_ff; // panel interface field

   // two flops for every strap and host pin input
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_s1_ff <= 3'h0;
         strap_s2_ff <= 3'h0;
         // host pins park idle high so no false strobe follows reset
         host_s1_ff <= `SLPM_HOST_IDLE;
         host_s2_ff <= `SLPM_HOST_IDLE;
      end else begin
         strap_s1_ff <= config_straps;
         strap_s2_ff <= strap_s1_ff;
         host_s1_ff <= {host_addr_bus[1:0], host_cs_n, host_rd_pin_n,
                        host_wr_pin_n};
         host_s2_ff <= host_s1_ff;
      end
   end

   //*************************************************
   // strap capture
   //*************************************************
   // the capture waits two clocks for the synchroniser to fill, so the
   // latch never takes the reset value still held in the second stage
   reg [1:0] settle_ff; // settle counter after release
   wire latch_rst_n; // latch held in reset until the straps have settled
   // counts up after release and parks at its last value
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_ff <= 2'h0;
      end else if (settle_ff != `SLPM_SETTLE_LAST) begin
         settle_ff <= settle_ff + 2'h1;
      end
   end

   // asserts with the pin reset at once; releases from a flop output
   // only, so the latch reset cannot glitch; bit 1 stays set once the
   // counter parks, so the capture happens once per reset
   // a user must keep the straps steady until this release has passed
   assign latch_rst_n = presetn & settle_ff[1];

   // one capture per reset release, held until the next reset
   slpm_strap_latch u_latch (
      .pclk(pclk),
      .presetn(latch_rst_n),
      .straps_sync(strap_s2_ff),
      .straps_ff(straps_cfg),
      .captured_ff(strap_done)
   );

   //*************************************************
   // host port mapping
   //*************************************************
   reg addr2_s1_ff; // top address bit first stage
   reg addr2_s2_ff; // top address bit synchronised
   // top address bit takes the same two stages as the other host pins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr2_s1_ff <= 1'b0;
         addr2_s2_ff <= 1'b0;
      end else begin
         addr2_s1_ff <= host_addr_bus[2];
         addr2_s2_ff <= addr2_s1_ff;
      end
   end

   // rd/wr pins keep or swap meaning by host bus style
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_rd_strobe_n <= 1'b1;
         host_wr_strobe_n <= 1'b1;
         host_cs_out_n <= 1'b1;
         host_addr_out <= 3'h0;
         big_endian <= 1'b0;
         host_bus_68 <= 1'b0;
         strap_fault <= 1'b0;
      end else begin
         host_cs_out_n <= host_s2_ff[2];
         host_addr_out <= {addr2_s2_ff, host_s2_ff[4:3]}; // see [R8]
         big_endian <= straps_cfg[`SLPM_STRAP_ORDER]; // see [R5]
         host_bus_68 <= straps_cfg[`SLPM_STRAP_HBUS];
         strap_fault <= strap_done & straps_cfg[`SLPM_STRAP_RSVD]; // see [R6]
         // rd/wr pins keep or swap meaning by the captured host style;
         // the style comes from the latched strap, never the live pin
         {host_rd_strobe_n, host_wr_strobe_n} <=
            slpm_host_strobes(straps_cfg[`SLPM_STRAP_HBUS],
                              host_s2_ff[1], host_s2_ff[0]); // see [R3]
      end
   end

   //*************************************************
   // panel pin mapping
   //*************************************************
   // each mode routes its own source set to the shared panel pins; pins
   // that the mode does not use park at their idle level
   // a mode change shows on the pins one clock after the field write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_frame <= 1'b0;
         pin_line <= 1'b0;
         pin_shift <= 1'b0;
         pin_drdy <= 1'b0;
         pin_cs1_n <= 1'b1;
         pin_sck <= 1'b0;
         pin_a0 <= 1'b0;
         pin_so <= 1'b0;
         panel_mode <= `SLPM_PANEL_MODE_RST;
      end else begin
         panel_mode <= panel_mode_ff;
         case (panel_mode_ff) // see [R7]
            `SLPM_MODE_RGB: begin
               // sync and clock pins drive the rgb timing
               pin_frame <= pnl_vsync;
               pin_line <= pnl_hsync;
               pin_shift <= pnl_dclk;
               pin_drdy <= pnl_den;
               pin_cs1_n <= 1'b1;
               pin_sck <= 1'b0;
               pin_a0 <= 1'b0;
               pin_so <= 1'b0;
            end
            `SLPM_MODE_SERIAL: begin
               // rgb timing plus serial command pins
               pin_frame <= pnl_vsync;
               pin_line <= pnl_hsync;
               pin_shift <= pnl_dclk;
               pin_drdy <= pnl_den;
               pin_cs1_n <= pnl_ser_cs_n;
               pin_sck <= pnl_ser_clk;
               pin_a0 <= pnl_ser_a0;
               pin_so <= pnl_ser_do;
            end
            `SLPM_MODE_PARALLEL: begin
               // frame becomes write strobe, line becomes a0
               pin_frame <= pnl_par_wr_n;
               pin_line <= pnl_par_a0;
               pin_shift <= 1'b0;
               pin_drdy <= 1'b0;
               pin_cs1_n <= pnl_par_cs_n;
               pin_sck <= 1'b0;
               pin_a0 <= 1'b0;
               pin_so <= 1'b0;
            end
            default: begin
               // unused mode parks every pin idle
               pin_frame <= 1'b0;
               pin_line <= 1'b0;
               pin_shift <= 1'b0;
               pin_drdy <= 1'b0;
               pin_cs1_n <= 1'b1;
               pin_sck <= 1'b0;
               pin_a0 <= 1'b0;
               pin_so <= 1'b0;
            end
         endcase
      end
   end

   //*************************************************
   // apb slave
   //*************************************************
   wire apb_setup; // setup phase of a transfer
   wire hit_cfg; // panel config selected
   wire hit_stat; // strap status selected
   wire [31:0] cfg_word; // read view of the panel field
   wire [31:0] stat_word; // read view of the capture flag and straps
   assign apb_setup = psel & ~penable;
   assign hit_cfg = slpm_hit(paddr, `SLPM_PANEL_CFG_BADDR);
   assign hit_stat = slpm_hit(paddr, `SLPM_STRAP_STAT_BADDR);
   // unused bits read as zero so software can widen the fields later
   assign cfg_word = {30'h0, panel_mode_ff};
   assign stat_word = {28'h0, strap_done, straps_cfg};

   // an unmapped address is refused: error with ready, no write, and
   // read data of zero, so a stray access cannot change the panel mode
   // the answer never takes a wait state, whatever the address
   // pready falls again at the access edge, so a held psel with penable
   // high never sees a second answer
   // no wait state: answer registered in setup, ready in the first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         panel_mode_ff <= `SLPM_PANEL_MODE_RST;
      end else begin
         pready <= apb_setup;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (apb_setup) begin
            if (hit_cfg) begin
               if (!pwrite) begin
                  prdata <= cfg_word;
               end
            end else if (hit_stat) begin
               if (!pwrite) begin
                  prdata <= stat_word;
               end
            end else begin
               pslverr <= 1'b1;
            end
         end
         // write lands at the access edge with ready
         if (psel & penable & pready & pwrite & hit_cfg) begin
            panel_mode_ff <= pwdata[`SLPM_PANEL_MODE_MSB:`SLPM_PANEL_MODE_LSB];
         end
      end
   end
endmodule // slpm_top
`default_nettype wire

// File: hw/slpm_map.vh
// register offsets, field positions, reset values and encodings for the strap and pin mapper
`ifndef SLPM_MAP_VH
`define SLPM_MAP_VH
// apb addresses: word offset of the panel config, then byte addresses
`define SLPM_PANEL_CFG_ADDR 12'h032
`define SLPM_PANEL_CFG_BADDR 12'h0C8
`define SLPM_STRAP_STAT_BADDR 12'h0CC
`define SLPM_ADDR_W 12
// panel interface field
`define SLPM_PANEL_MODE_LSB 0
`define SLPM_PANEL_MODE_MSB 1
`define SLPM_PANEL_MODE_RST 2'h0
// panel modes
`define SLPM_MODE_RGB 2'h0
`define SLPM_MODE_SERIAL 2'h1
`define SLPM_MODE_PARALLEL 2'h2
`define SLPM_MODE_OFF 2'h3
// strap bit positions
`define SLPM_STRAP_RSVD 0
`define SLPM_STRAP_HBUS 1
`define SLPM_STRAP_ORDER 2
`define SLPM_STRAP_RST 3'h0
// host pin synchroniser idle value: strobes and select high
`define SLPM_HOST_IDLE 5'h1F
// last count of the strap settle counter after reset release
`define SLPM_SETTLE_LAST 2'h3
`endif

// File: hw/slpm_strap_latch.v
// strap capture register: samples straps once after reset release
`timescale 1ns/1ns
`default_nettype none
`include "slpm_map.vh"
module slpm_strap_latch (
   input wire pclk,
   input wire presetn,
   input wire [2:0] straps_sync,
   output reg [2:0] straps_ff,
   output reg captured_ff
);
   // capture on the first clock after release, then hold until next reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         straps_ff <= `SLPM_STRAP_RST;
         captured_ff <= 1'b0;
      end else if (!captured_ff) begin
         straps_ff <= straps_sync; // see [R1]
         captured_ff <= 1'b1;
      end
      // later strap changes are ignored here // see [R2]
   end
endmodule // slpm_strap_latch
`default_nettype wire

// File: test/slpm_properties.sv
// checker of the strap latch and pin mapper outputs
`timescale 1ns/1ns
`default_nettype none
module slpm_properties (
   input wire logic pclk, presetn, pslverr, host_rd_pin_n, host_wr_pin_n,
   input wire logic [2:0] config_straps,
   input wire logic host_rd_strobe_n, host_wr_strobe_n, big_endian,
   input wire logic host_bus_68, strap_fault, pnl_vsync, pnl_hsync, pnl_den,
   input wire logic pnl_par_wr_n, pnl_par_a0, pnl_par_cs_n, pin_frame,
   input wire logic pin_line, pin_drdy, pin_cs1_n,
   input wire logic [1:0] panel_mode
);
   // ********************************
   // helper counter and assertions
   // ********************************
   logic [3:0] up_ff; // edges since reset release, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) up_ff <= 4'h0;
      else if (up_ff != 4'hF) up_ff <= up_ff + 4'h1;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_cap; $rose(presetn) |-> ##5
      {big_endian, host_bus_68, strap_fault} == $past(config_straps, 3);
   endproperty
   a_cap: assert property (p_cap) else $error("bad capture");
   property p_hold; up_ff == 4'hF |->
      $stable({big_endian, host_bus_68, strap_fault}); endproperty
   a_hold: assert property (p_hold) else $error("straps moved");
   property p_h80; up_ff == 4'hF && !host_bus_68 |->
      host_rd_strobe_n == $past(host_rd_pin_n, 3) &&
      host_wr_strobe_n == $past(host_wr_pin_n, 3); endproperty
   a_h80: assert property (p_h80) else $error("80 strobes");
   property p_h68; up_ff == 4'hF && host_bus_68 |->
      host_rd_strobe_n == ($past(host_rd_pin_n, 3) | ~$past(host_wr_pin_n, 3))
      && host_wr_strobe_n == ($past(host_rd_pin_n, 3) | $past(host_wr_pin_n, 3));
   endproperty
   a_h68: assert property (p_h68) else $error("68 strobes");
   property p_rgb; up_ff > 4'h2 && !panel_mode[1] && !$past(panel_mode[1])
      |-> pin_frame == $past(pnl_vsync) && pin_line == $past(pnl_hsync)
      && pin_drdy == $past(pnl_den); endproperty
   a_rgb: assert property (p_rgb) else $error("rgb pins");
   property p_par; up_ff > 4'h2 && panel_mode == 2'h2 &&
      $past(panel_mode) == 2'h2 |-> pin_frame == $past(pnl_par_wr_n) &&
      pin_line == $past(pnl_par_a0) && pin_cs1_n == $past(pnl_par_cs_n);
   endproperty
   a_par: assert property (p_par) else $error("parallel pins");
   property p_off; panel_mode == 2'h3 && $past(panel_mode) == 2'h3 |->
      {pin_frame, pin_line, pin_drdy, pin_cs1_n} == 4'h1; endproperty
   a_off: assert property (p_off) else $error("idle pins");
   c_68: cover property (host_bus_68 && !host_wr_strobe_n);
   c_off: cover property (panel_mode == 2'h3);
   c_err: cover property (pslverr);
endmodule // slpm_properties
bind slpm_top slpm_properties u_slpm_properties (.*);
`default_nettype wire

// File: test/slpm_host_model.sv
// host processor model driving the indirect parallel host pins
`timescale 1ns/1ns
`default_nettype none
module slpm_host_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic host_bus_68,
   output logic host_cs_n,
   output logic host_rd_pin_n,
   output logic host_wr_pin_n,
   output logic [2:0] host_addr_bus
);
   integer seed = 32'hc2f76ce0; // random stream of the host
   logic [5:0] r; // fresh random pin pattern
   initial {host_cs_n, host_rd_pin_n, host_wr_pin_n, host_addr_bus} = 6'h38;
   // random cycles; strobes idle high in reset, address keeps wandering
   always @(posedge pclk) begin
      r = 6'($random(seed));
      host_addr_bus <= presetn ? r[3:1] : ~host_addr_bus;
      host_cs_n <= r[0] | ~presetn;
      host_rd_pin_n <= r[4] | ~presetn;
      // in 80 style never both strobes low at once
      host_wr_pin_n <= (host_bus_68 ? r[5] : r[5] | ~r[4]) | ~presetn;
   end
endmodule // slpm_host_model
`default_nettype wire

// File: test/slpm_top_tb.sv
// self-checking bench of the strap latch and pin mapper
`timescale 1ns/1ns
`default_nettype none
module slpm_top_tb;
   // ********************************
   // signals, design and host model
   // ********************************
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] config_straps, host_addr_bus, host_addr_out;
   logic host_cs_n, host_rd_pin_n, host_wr_pin_n, host_cs_out_n, big_endian;
   logic host_rd_strobe_n, host_wr_strobe_n, host_bus_68, strap_fault;
   logic pin_frame, pin_line, pin_shift, pin_drdy, pin_cs1_n, pin_sck;
   logic pin_a0, pin_so;
   logic [1:0] panel_mode;
   wire logic pnl_vsync, pnl_hsync, pnl_dclk, pnl_den, pnl_ser_cs_n;
   wire logic pnl_ser_clk, pnl_ser_a0, pnl_ser_do, pnl_par_wr_n, pnl_par_a0;
   wire logic pnl_par_cs_n;
   logic [10:0] pnl, s, p; // panel sources, current and previous
   logic [17:0] hq; // host pin history, oldest in the top slice
   integer n_mismatch = 0, n_checks = 0, seed = 32'hc2f76ce0, i, j, k;
   assign {pnl_par_cs_n, pnl_par_a0, pnl_par_wr_n, pnl_ser_do, pnl_ser_a0,
      pnl_ser_clk, pnl_ser_cs_n, pnl_den, pnl_dclk, pnl_hsync, pnl_vsync} = pnl;
   slpm_top u_slpm_top (.*);
   slpm_host_model u_slpm_host_model (.*);
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk)
      hq <= {hq[11:0], host_cs_n, host_rd_pin_n, host_wr_pin_n, host_addr_bus};
   // ********************************
   // model, compare and bus tasks
   // ********************************
   function automatic logic [5:0] hexp(input logic [5:0] x, input logic m);
      hexp = x;
      if (m) hexp[4:3] = {x[4] | ~x[3], x[4] | x[3]};
   endfunction
   function automatic logic [7:0] pexp(input logic [1:0] m, logic [10:0] x);
      case (m)
         2'h0: pexp = {x[0], x[1], x[2], x[3], 4'h8};
         2'h1: pexp = {x[0], x[1], x[2], x[3], x[4], x[5], x[6], x[7]};
         2'h2: pexp = {x[8], x[9], 2'h0, x[10], 3'h0};
         default: pexp = 8'h08;
      endcase
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic xe);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (j = 0; j < 20 && pready !== 1'b1; j++) @(posedge pclk);
      if (j == 20) n_mismatch++;
      if (j == 20) results;
      rd = prdata;
      chk({31'h0, pslverr}, {31'h0, xe});
      {psel, penable} <= 2'h0;
   endtask
   // ********************************
   // main sequence
   // ********************************
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
      {config_straps, pnl, hq} = 32'h0;
      for (i = 0; i < 4; i++) begin
         @(posedge pclk);
         presetn <= 1'b0;
         config_straps <= {i[1:0], 1'b0};
         repeat (16) @(posedge pclk);
         presetn <= 1'b1;
         repeat (8) @(posedge pclk);
         config_straps <= {~i[1:0], 1'b0};
         apb(1'b0, 12'h0CC, 32'h0, 1'b0);
         chk(rd, {28'h0, 1'b1, i[1:0], 1'b0});
         chk({big_endian, host_bus_68, strap_fault}, {i[1:0], 1'b0});
         for (k = 0; k < 30; k++) begin
            @(negedge pclk);
            chk({host_cs_out_n, host_rd_strobe_n, host_wr_strobe_n,
               host_addr_out}, hexp(hq[17:12], i[0]));
         end
         $display("strap test %0d done", i);
      end
      apb(1'b0, 12'h0C4, 32'h0, 1'b1);
      chk(rd, 32'h0);
      for (i = 0; i < 4; i++) begin
         apb(1'b1, 12'h0C8, i, 1'b0);
         apb(1'b0, 12'h0C8, 32'h0, 1'b0);
         chk(rd, i);
         chk({30'h0, panel_mode}, {30'h0, i[1:0]});
         @(posedge pclk);
         s = 11'($random(seed));
         pnl <= s;
         for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            p = s;
            s = 11'($random(seed));
            pnl <= s;
            @(negedge pclk);
            chk({pin_frame, pin_line, pin_shift, pin_drdy, pin_cs1_n, pin_sck,
               pin_a0, pin_so}, pexp(i[1:0], p));
         end
         $display("panel mode %0d done", i);
      end
      results;
   end
endmodule // slpm_top_tb
`default_nettype wire
